// [logic/crhl_pkg.sv]
package crhl_pkg;
  // Clock and serial timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
  // Handshake timeouts in milliseconds and derived cycles
  localparam int unsigned ACK_WAIT_MS = 20;
  localparam int unsigned ACK_WAIT_CYC = ACK_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned RESYNC_MS = 15;
  localparam int unsigned RESYNC_CYC = RESYNC_MS * (CLK_HZ / 1000);
  localparam int unsigned RESULT_MS = 300;
  localparam int unsigned RESULT_CYC = RESULT_MS * (CLK_HZ / 1000);
  localparam int unsigned REPLY_GAP_MS = 45;
  localparam int unsigned REPLY_GAP_CYC = REPLY_GAP_MS * (CLK_HZ / 1000);
  // Control characters
  localparam logic [7:0] CH_START = 8'h02;
  localparam logic [7:0] CH_END = 8'h03;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  // Block limits and status
  localparam logic [7:0] CMD_MAX_LEN = 8'h16;
  localparam logic [7:0] RSP_MAX_LEN = 8'h10;
  localparam logic [7:0] LINK_FAULT_STATUS = 8'hFF;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam int unsigned BUF_DEPTH = 32;
  // Opcodes
  localparam logic [7:0] OP_POLL = 8'h41;
  localparam logic [7:0] OP_RESOLVE = 8'h42;
  localparam logic [7:0] OP_SELECT = 8'h43;
  localparam logic [7:0] OP_VERIFY = 8'h44;
  localparam logic [7:0] OP_SLEEP = 8'h45;
  localparam logic [7:0] OP_BLK_READ = 8'h46;
  localparam logic [7:0] OP_BLK_WRITE = 8'h47;
  localparam logic [7:0] OP_INCR = 8'h48;
  localparam logic [7:0] OP_DECR = 8'h49;
  localparam logic [7:0] OP_RESTORE = 8'h4A;
  localparam logic [7:0] OP_TRANSFER = 8'h4B;
  localparam logic [7:0] OP_STORED_KEY_UPDATE = 8'h4C;
  localparam logic [7:0] OP_FIELD_OFF = 8'h4E;
  localparam logic [7:0] OP_BUZZER = 8'h60;
  localparam logic [7:0] OP_LOCAL_NVM_FETCH = 8'h61;
  localparam logic [7:0] OP_LOCAL_NVM_STORE = 8'h62;
  localparam logic [7:0] OP_VALUE = 8'h70;
  localparam logic [7:0] OP_MULTI_CARD_RESOLVE = 8'h71;
  localparam logic [7:0] OP_KEYSLOT_VERIFY = 8'h72;
  localparam logic [7:0] OP_DIRECT_KEY_VERIFY = 8'h73;
  localparam logic [7:0] OP_STANDBY = 8'h3F;
endpackage

// [logic/crhl_mem.sv]
`timescale 1ns/10ps
`default_nettype none
// Small byte store with registered read data
module crhl_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [DEPTH];  // Storage, no reset needed
  // Write port and registered read
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// [logic/crhl_host.sv]
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - 8N1 at 9600 baud, LSB first
// - Start 02, end 03, ack 06, nak 15
// - Resend start if no answer in 20ms
// - Begin command block within 45ms of ack
// - Inter-byte gap below 15ms while sending
// - Byte during send: stop, wait 15ms, retry
// - Send end character, await result transfer
// - Host acks device start character
// - Block: seq, opcode, length, payload, check
// - Sequence increments after each good exchange
// - Command payload length 0 to 22
// - Check byte is XOR of preceding bytes
module crhl_host #(
  parameter int unsigned ACK_WAIT = crhl_pkg::ACK_WAIT_CYC,
  parameter int unsigned RESYNC = crhl_pkg::RESYNC_CYC,
  parameter int unsigned RESULT_WAIT = crhl_pkg::RESULT_CYC,
  parameter int unsigned BIT_CYC = crhl_pkg::BIT_CYCLES,
  parameter int unsigned RETRIES = 3
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [4:0] i_len,
  input wire logic i_pay_we,
  input wire logic [4:0] i_pay_addr,
  input wire logic [7:0] i_pay_data,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_status,
  output logic [7:0] o_seq,
  output logic [4:0] o_rsp_len,
  output logic o_rsp_we,
  output logic [3:0] o_rsp_addr,
  output logic [7:0] o_rsp_data
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_TX_STX = 4'h1, S_WAIT_ACK = 4'h2, S_TX_BLK = 4'h3,
    S_TX_ETX = 4'h4, S_WAIT_RES = 4'h5, S_TX_ACK = 4'h6, S_RX_BLK = 4'h7,
    S_RX_ETX = 4'h8, S_RESYNC = 4'h9, S_FINISH = 4'hA
  } crhl_state_type;

  // Check a byte is a known opcode
  function automatic logic crhl_known_op(input logic [7:0] op);
    case (op)
      crhl_pkg::OP_POLL, crhl_pkg::OP_RESOLVE, crhl_pkg::OP_SELECT,
      crhl_pkg::OP_MULTI_CARD_RESOLVE, crhl_pkg::OP_VERIFY,
      crhl_pkg::OP_KEYSLOT_VERIFY, crhl_pkg::OP_DIRECT_KEY_VERIFY,
      crhl_pkg::OP_BLK_READ, crhl_pkg::OP_BLK_WRITE, crhl_pkg::OP_SLEEP,
      crhl_pkg::OP_INCR, crhl_pkg::OP_DECR, crhl_pkg::OP_RESTORE,
      crhl_pkg::OP_TRANSFER, crhl_pkg::OP_VALUE, crhl_pkg::OP_FIELD_OFF,
      crhl_pkg::OP_STANDBY, crhl_pkg::OP_BUZZER, crhl_pkg::OP_LOCAL_NVM_FETCH,
      crhl_pkg::OP_LOCAL_NVM_STORE, crhl_pkg::OP_STORED_KEY_UPDATE: crhl_known_op = 1'b1;
      default: crhl_known_op = 1'b0;
    endcase
  endfunction

  // Receive synchroniser: first stage read only by the second
  logic rx_s1_ff, rx_s2_ff;
  always_ff @(posedge i_clk) begin
    rx_s1_ff <= i_rxd;
    rx_s2_ff <= rx_s1_ff;
  end

  // Serial transmitter and receiver state
  logic [15:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [9:0] tx_sh_ff, nxt_tx_sh;
  logic tx_busy_ff, nxt_tx_busy;
  logic [15:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [7:0] rx_sh_ff, nxt_rx_sh;
  logic rx_busy_ff, nxt_rx_busy;
  logic rx_vld_ff, nxt_rx_vld;   // One-cycle byte strobe
  logic [7:0] rx_byte_ff, nxt_rx_byte;
  logic tx_go;                    // Load request from control
  logic [7:0] tx_byte;
  logic [15:0] bit_len, half_len;
  assign bit_len = 16'(BIT_CYC);
  assign half_len = 16'(BIT_CYC / 2);

  // Character timing, start + 8 data + stop, LSB first
  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_busy = tx_busy_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_busy = rx_busy_ff;
    nxt_rx_vld = 1'b0;
    nxt_rx_byte = rx_byte_ff;
    if (!tx_busy_ff) begin
      if (tx_go) begin
        nxt_tx_sh = {1'b1, tx_byte, 1'b0};
        nxt_tx_busy = 1'b1;
        nxt_tx_cnt = bit_len - 16'h0001;
        nxt_tx_bit = 4'h0;
      end
    end else if (tx_cnt_ff == 16'h0000) begin
      nxt_tx_sh = {1'b1, tx_sh_ff[9:1]};
      nxt_tx_cnt = bit_len - 16'h0001;
      nxt_tx_bit = tx_bit_ff + 4'h1;
      if (tx_bit_ff == 4'h9) begin
        nxt_tx_busy = 1'b0;
      end
    end else begin
      nxt_tx_cnt = tx_cnt_ff - 16'h0001;
    end
    if (!rx_busy_ff) begin
      if (!rx_s2_ff) begin
        nxt_rx_busy = 1'b1;
        nxt_rx_cnt = half_len;
        nxt_rx_bit = 4'h0;
      end
    end else if (rx_cnt_ff == 16'h0000) begin
      nxt_rx_cnt = bit_len - 16'h0001;
      nxt_rx_bit = rx_bit_ff + 4'h1;
      if (rx_bit_ff == 4'h0 && rx_s2_ff) begin
        nxt_rx_busy = 1'b0;       // False start glitch
      end else if (rx_bit_ff == 4'h9) begin
        nxt_rx_busy = 1'b0;
        nxt_rx_vld = rx_s2_ff;    // Drop bytes with bad stop bit
        nxt_rx_byte = rx_sh_ff;
      end else if (rx_bit_ff != 4'h0) begin
        nxt_rx_sh = {rx_s2_ff, rx_sh_ff[7:1]};
      end
    end else begin
      nxt_rx_cnt = rx_cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 10'h3FF;
      tx_busy_ff <= 1'b0;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      rx_busy_ff <= 1'b0;
      rx_vld_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_busy_ff <= nxt_tx_busy;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_busy_ff <= nxt_rx_busy;
      rx_vld_ff <= nxt_rx_vld;
      rx_byte_ff <= nxt_rx_byte;
    end
  end

  // Payload store, read address driven by control
  logic [4:0] mem_raddr;
  logic [7:0] mem_rdata;
  crhl_mem #(.DEPTH(crhl_pkg::BUF_DEPTH), .AW(5)) u_pay (
    .i_clk(i_clk),
    .i_we(i_pay_we & ~o_busy),
    .i_waddr(i_pay_addr),
    .i_wdata(i_pay_data),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // Exchange control
  crhl_state_type st_ff, nxt_st;
  logic [24:0] tmr_ff, nxt_tmr;    // Timeout counter
  logic [5:0] idx_ff, nxt_idx;     // Byte index inside block
  logic [7:0] xor_ff, nxt_xor;
  logic [7:0] seq_ff, nxt_seq;
  logic [7:0] op_ff, nxt_op;
  logic [4:0] len_ff, nxt_len;
  logic [1:0] try_ff, nxt_try;
  logic [7:0] rlen_ff, nxt_rlen;
  logic [7:0] rstat_ff, nxt_rstat;
  logic rseq_ok_ff, nxt_rseq_ok;
  logic done_ff, nxt_done;
  logic [7:0] status_ff, nxt_status;
  logic [4:0] olen_ff, nxt_olen;
  logic rwe_ff, nxt_rwe;
  logic [3:0] raddr_ff, nxt_raddr;
  logic [7:0] rdat_ff, nxt_rdat;
  logic [7:0] blk_byte;
  logic tx_idle;
  // Idle comes from the register only, so the load request never feeds back on itself
  assign tx_idle = ~tx_busy_ff;
  assign mem_raddr = 5'(idx_ff - 6'h03);

  // Outgoing byte of the command block
  always_comb begin
    case (idx_ff)
      6'h00: blk_byte = seq_ff;
      6'h01: blk_byte = op_ff;
      6'h02: blk_byte = {3'b000, len_ff};
      default: blk_byte = (idx_ff == 6'(len_ff) + 6'h03) ? xor_ff : mem_rdata;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff + 25'h0000001;
    nxt_idx = idx_ff;
    nxt_xor = xor_ff;
    nxt_seq = seq_ff;
    nxt_op = op_ff;
    nxt_len = len_ff;
    nxt_try = try_ff;
    nxt_rlen = rlen_ff;
    nxt_rstat = rstat_ff;
    nxt_rseq_ok = rseq_ok_ff;
    nxt_done = 1'b0;
    nxt_status = status_ff;
    nxt_olen = olen_ff;
    nxt_rwe = 1'b0;
    nxt_raddr = raddr_ff;
    nxt_rdat = rdat_ff;
    tx_go = 1'b0;
    tx_byte = crhl_pkg::CH_START;
    case (st_ff)
      S_IDLE: begin
        nxt_tmr = 25'h0000000;
        if (i_start) begin
          nxt_op = i_opcode;
          nxt_len = (i_len > 5'(crhl_pkg::CMD_MAX_LEN)) ? 5'(crhl_pkg::CMD_MAX_LEN) : i_len;
          nxt_try = 2'b00;
          nxt_st = crhl_known_op(i_opcode) ? S_TX_STX : S_FINISH;
          nxt_status = crhl_pkg::LINK_FAULT_STATUS;
          nxt_olen = 5'h00;
        end
      end
      S_TX_STX: begin
        if (tx_idle) begin
          tx_go = 1'b1;
          tx_byte = crhl_pkg::CH_START;
          nxt_tmr = 25'h0000000;
          nxt_st = S_WAIT_ACK;
        end
      end
      S_WAIT_ACK: begin
        if (rx_vld_ff && rx_byte_ff == crhl_pkg::CH_ACK) begin
          nxt_idx = 6'h00;               // Block starts at once, well inside 45ms
          nxt_xor = 8'h00;
          nxt_st = S_TX_BLK;
        end else if ((rx_vld_ff && rx_byte_ff == crhl_pkg::CH_NAK) ||
                     tmr_ff >= 25'(ACK_WAIT)) begin
          nxt_try = try_ff + 2'b01;
          nxt_tmr = 25'h0000000;
          nxt_st = (32'(try_ff) + 1 >= RETRIES) ? S_FINISH : S_RESYNC;
        end
      end
      S_TX_BLK: begin
        if (rx_vld_ff) begin
          nxt_tmr = 25'h0000000;
          nxt_st = S_RESYNC;
        end else if (tx_idle) begin
          tx_go = 1'b1;                  // Back to back bytes, gap far below 15ms
          tx_byte = blk_byte;
          nxt_xor = xor_ff ^ blk_byte;
          nxt_idx = idx_ff + 6'h01;
          if (idx_ff == 6'(len_ff) + 6'h03) begin
            nxt_st = S_TX_ETX;
          end
        end
      end
      S_TX_ETX: begin
        if (tx_idle) begin
          tx_go = 1'b1;
          tx_byte = crhl_pkg::CH_END;
          nxt_tmr = 25'h0000000;
          nxt_st = S_WAIT_RES;
        end
      end
      S_WAIT_RES: begin
        if (rx_vld_ff && rx_byte_ff == crhl_pkg::CH_START) begin
          nxt_st = S_TX_ACK;
        end else if (tmr_ff >= 25'(RESULT_WAIT)) begin
          nxt_st = S_FINISH;             // Device overran its limit
        end
      end
      S_TX_ACK: begin
        if (tx_idle) begin
          tx_go = 1'b1;
          tx_byte = crhl_pkg::CH_ACK;
          nxt_tmr = 25'h0000000;
          nxt_idx = 6'h00;
          nxt_xor = 8'h00;
          nxt_st = S_RX_BLK;
        end
      end
      S_RX_BLK: begin
        if (tmr_ff >= 25'(crhl_pkg::REPLY_GAP_CYC)) begin
          nxt_st = S_FINISH;             // Response stalled or never came
        end else if (rx_vld_ff) begin
          nxt_tmr = 25'h0000000;
          nxt_xor = xor_ff ^ rx_byte_ff;
          nxt_idx = idx_ff + 6'h01;
          case (idx_ff)
            6'h00: nxt_rseq_ok = (rx_byte_ff == seq_ff);
            6'h01: nxt_rstat = rx_byte_ff;
            6'h02: begin
              nxt_rlen = rx_byte_ff;
              if (rx_byte_ff > crhl_pkg::RSP_MAX_LEN) begin
                nxt_st = S_FINISH;
              end
            end
            default: begin
              if (idx_ff == 6'(rlen_ff) + 6'h03) begin
                nxt_st = S_RX_ETX;
                if (xor_ff == rx_byte_ff && rseq_ok_ff) begin
                  nxt_status = rstat_ff;
                  nxt_olen = (rstat_ff == crhl_pkg::STATUS_OK) ? 5'(rlen_ff) : 5'h00;
                end
              end else begin
                nxt_rwe = 1'b1;
                nxt_raddr = 4'(idx_ff - 6'h03);
                nxt_rdat = rx_byte_ff;
              end
            end
          endcase
        end
      end
      S_RX_ETX: begin
        if (rx_vld_ff || tmr_ff >= 25'(crhl_pkg::REPLY_GAP_CYC)) begin
          if (!(rx_vld_ff && rx_byte_ff == crhl_pkg::CH_END)) begin
            nxt_status = crhl_pkg::LINK_FAULT_STATUS;
            nxt_olen = 5'h00;
          end
          nxt_st = S_FINISH;
        end
      end
      S_RESYNC: begin
        if (tmr_ff >= 25'(RESYNC)) begin
          nxt_st = S_TX_STX;             // Quiet wait then fresh handshake
        end
      end
      S_FINISH: begin
        nxt_done = 1'b1;
        if (status_ff != crhl_pkg::LINK_FAULT_STATUS) begin
          nxt_seq = seq_ff + 8'h01;
        end
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_ff <= S_IDLE;
      tmr_ff <= 25'h0000000;
      idx_ff <= 6'h00;
      xor_ff <= 8'h00;
      seq_ff <= 8'h00;
      op_ff <= 8'h00;
      len_ff <= 5'h00;
      try_ff <= 2'b00;
      rlen_ff <= 8'h00;
      rstat_ff <= 8'h00;
      rseq_ok_ff <= 1'b0;
      done_ff <= 1'b0;
      status_ff <= 8'h00;
      olen_ff <= 5'h00;
      rwe_ff <= 1'b0;
      raddr_ff <= 4'h0;
      rdat_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      idx_ff <= nxt_idx;
      xor_ff <= nxt_xor;
      seq_ff <= nxt_seq;
      op_ff <= nxt_op;
      len_ff <= nxt_len;
      try_ff <= nxt_try;
      rlen_ff <= nxt_rlen;
      rstat_ff <= nxt_rstat;
      rseq_ok_ff <= nxt_rseq_ok;
      done_ff <= nxt_done;
      status_ff <= nxt_status;
      olen_ff <= nxt_olen;
      rwe_ff <= nxt_rwe;
      raddr_ff <= nxt_raddr;
      rdat_ff <= nxt_rdat;
    end
  end

  // Busy is a registered view of the state
  logic busy_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_st != S_IDLE);
    end
  end

  assign o_txd = tx_sh_ff[0];
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_status = status_ff;
  assign o_seq = seq_ff;
  assign o_rsp_len = olen_ff;
  assign o_rsp_we = rwe_ff;
  assign o_rsp_addr = raddr_ff;
  assign o_rsp_data = rdat_ff;

  // Line idles high whenever no character is in flight
  a_txd_idle_high: assert property (@(posedge i_clk) disable iff (i_reset)
    !tx_busy_ff |-> o_txd) else $error("txd low while idle");
  // Start character follows the start request
  a_start_sends_stx: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_ff == S_TX_STX && tx_idle) |=> (tx_sh_ff[8:1] == crhl_pkg::CH_START && !o_txd))
    else $error("start character not sent");
  // Ack wait never outlives its bound
  a_ack_wait_bound: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_ff == S_WAIT_ACK) |-> tmr_ff <= 25'(ACK_WAIT)) else $error("ack wait overrun");
  // Any byte while sending aborts the block
  a_sync_loss_abort: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_ff == S_TX_BLK && rx_vld_ff) |=> st_ff == S_RESYNC) else $error("no resync");
  // End character follows the last block byte
  a_etx_after_blk: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_ff == S_TX_ETX && tx_idle) |=> (st_ff == S_WAIT_RES && tx_sh_ff[8:1] == crhl_pkg::CH_END))
    else $error("end character missing");
  // Device start answered with ack
  a_ack_result: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_ff == S_WAIT_RES && rx_vld_ff && rx_byte_ff == crhl_pkg::CH_START)
    |=> st_ff == S_TX_ACK ##[1:3] tx_sh_ff[8:1] == crhl_pkg::CH_ACK) else $error("no ack");
  // Sequence advances only by one, on leaving S_FINISH
  a_seq_advance: assert property (@(posedge i_clk) disable iff (i_reset)
    $changed(seq_ff) |-> ($past(st_ff) == S_FINISH && seq_ff == $past(seq_ff) + 8'h01))
    else $error("bad sequence step");
  // Failed command leaves zero response length
  a_fail_len_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_done && o_status != crhl_pkg::STATUS_OK) |-> o_rsp_len == 5'h00)
    else $error("length on failure");
  // Command block length never above limit
  a_cmd_len_limit: assert property (@(posedge i_clk) disable iff (i_reset)
    len_ff <= 5'(crhl_pkg::CMD_MAX_LEN)) else $error("command too long");
endmodule
`default_nettype wire

// [verif/crhl_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Behavioural card reader on the far side of the serial link
module crhl_dev_model #(
  parameter int BIT = 16,
  parameter int GAP = 2000
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line,
  input wire logic i_nak,
  input wire logic i_bad_xor,
  input wire logic i_chatter,
  input wire logic [7:0] i_status,
  input wire logic [4:0] i_rsp_len,
  input wire logic [15:0] i_delay,
  output logic [7:0] o_seq,
  output logic [7:0] o_op,
  output logic [7:0] o_len,
  output logic [7:0] o_pay_xor,
  output logic o_xor_ok,
  output logic [7:0] o_frames
);
  logic [7:0] b, x, st, n;
  logic cut = 1'b0;  // Talked over the previous frame start
  logic late = 1'b0; // A block byte came after too long a gap
  // Receive one character, sampled mid bit, low bit first
  task automatic get_byte(output logic [7:0] v);
    int w;
    w = 0;
    while (i_line !== 1'b0) begin
      @(posedge i_clk);
      w++;
    end
    late |= (w > GAP); // Stale gap spoils the block
    repeat (BIT / 2) @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(posedge i_clk);
      v[k] = i_line;
    end
    repeat (BIT) @(posedge i_clk);
  endtask
  // Send one character; line moves just after an edge
  task automatic put_byte(input logic [7:0] v);
    o_line <= 1'b0;
    repeat (BIT) @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      o_line <= v[k];
      repeat (BIT) @(posedge i_clk);
    end
    o_line <= 1'b1;
    repeat (BIT) @(posedge i_clk);
  endtask
  // Every opcode gets the same generic answer block
  task automatic exchange();
    late = 1'b0;
    get_byte(o_seq);
    get_byte(o_op);
    get_byte(o_len);
    x = o_seq ^ o_op ^ o_len;
    o_pay_xor = 8'h00;
    for (int k = 0; k < o_len; k++) begin
      get_byte(b);
      x ^= b;
      o_pay_xor ^= b;
    end
    get_byte(b);
    o_xor_ok = (b === x);
    get_byte(b);
    // Limitation: the whole block is taken in before being dropped
    if (late) return;
    // Bad check: no execution, link fault status
    st = o_xor_ok ? i_status : crhl_pkg::LINK_FAULT_STATUS;
    n = (o_xor_ok && st == 8'h00) ? {3'b000, i_rsp_len} : 8'h00;
    repeat (i_delay) @(posedge i_clk);
    put_byte(crhl_pkg::CH_START);
    get_byte(b);
    // Host always answers here, so the abandon path is not modelled
    if (b === crhl_pkg::CH_ACK) begin
      x = o_seq ^ st ^ n;
      put_byte(o_seq);
      put_byte(st);
      put_byte(n);
      for (int k = 0; k < n; k++) begin
        b = o_seq ^ 8'hA5 ^ 8'(k);
        x ^= b;
        put_byte(b);
      end
      put_byte(i_bad_xor ? ~x : x);
      put_byte(crhl_pkg::CH_END);
    end
  endtask
  // Wait for a frame start, then accept or refuse it
  initial begin
    o_line = 1'b1;
    o_frames = 8'h00;
    forever begin
      get_byte(b);
      if (b === crhl_pkg::CH_START) begin
        o_frames = o_frames + 8'h01;
        cut = i_chatter && !cut;
        if (i_nak) put_byte(crhl_pkg::CH_NAK);
        else if (cut) begin
          // Talk over the host's block once to force a resync
          put_byte(crhl_pkg::CH_ACK);
          put_byte(crhl_pkg::CH_NAK);
        end else begin
          put_byte(crhl_pkg::CH_ACK);
          exchange();
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verif/card_reader_host_command_link_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// Host link bench: random exchanges plus fault corners
module card_reader_host_command_link_tb;
  logic i_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0, i_pay_we = 1'b0;
  logic [7:0] i_opcode = 8'h00, i_pay_data = 8'h00;
  logic [4:0] i_len = 5'h00, i_pay_addr = 5'h00;
  logic o_txd, o_busy, o_done, o_rsp_we, dev_line, m_ok;
  logic [7:0] o_status, o_seq, o_rsp_data, m_seq, m_op, m_len, m_px, m_fr;
  logic [4:0] o_rsp_len;
  logic [3:0] o_rsp_addr;
  // Far side knobs
  logic nak = 1'b0, bad_xor = 1'b0, chat = 1'b0;
  logic [7:0] dev_st = 8'h00;
  logic [4:0] dev_len = 5'h00;
  logic [15:0] dev_dly = 16'h0010;
  int bad_count = 0, n_tests = 0, seed = 32'h5ADF, rsp_cnt = 0;
  logic [7:0] exp_seq = 8'h00;
  logic [7:0] rsp_mem [16];
  logic [7:0] ops [21] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
    8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4E, 8'h60, 8'h61, 8'h62, 8'h70, 8'h71, 8'h72,
    8'h73, 8'h3F};
  always #12.5 i_clk = ~i_clk;
  crhl_host #(.ACK_WAIT(600), .RESYNC(300), .RESULT_WAIT(3000), .BIT_CYC(12))
    crhl_host_inst (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
    .i_opcode(i_opcode), .i_len(i_len), .i_pay_we(i_pay_we), .i_pay_addr(i_pay_addr),
    .i_pay_data(i_pay_data), .i_rxd(dev_line), .o_txd(o_txd), .o_busy(o_busy),
    .o_done(o_done), .o_status(o_status), .o_seq(o_seq), .o_rsp_len(o_rsp_len),
    .o_rsp_we(o_rsp_we), .o_rsp_addr(o_rsp_addr), .o_rsp_data(o_rsp_data));
  crhl_dev_model #(.BIT(12)) crhl_dev_model_inst (.i_clk(i_clk), .i_line(o_txd),
    .o_line(dev_line), .i_nak(nak), .i_bad_xor(bad_xor), .i_chatter(chat),
    .i_status(dev_st),
    .i_rsp_len(dev_len), .i_delay(dev_dly), .o_seq(m_seq), .o_op(m_op), .o_len(m_len),
    .o_pay_xor(m_px), .o_xor_ok(m_ok), .o_frames(m_fr));
  // Collect response payload as it is handed out
  always @(posedge i_clk) begin
    if (o_rsp_we === 1'b1) begin
      rsp_mem[o_rsp_addr] <= o_rsp_data;
      rsp_cnt <= rsp_cnt + 1;
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (e !== g) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Opcodes the link is expected to forward
  function automatic logic known(input logic [7:0] op);
    known = 1'b0;
    foreach (ops[i]) if (ops[i] == op) known = 1'b1;
  endfunction
  // One whole exchange and all its checks
  task automatic xfer(input logic [7:0] op, input logic [4:0] len, input logic [7:0] st,
    input logic [4:0] rl);
    logic [7:0] px, es, fr;
    logic [4:0] el;
    int cnt;
    px = 8'h00;
    fr = m_fr;
    for (int k = 0; k < len; k++) begin
      @(negedge i_clk);
      i_pay_we = 1'b1;
      i_pay_addr = 5'(k);
      i_pay_data = 8'($random(seed));
      px ^= i_pay_data;
    end
    @(negedge i_clk);
    i_pay_we = 1'b0;
    dev_st = st;
    dev_len = rl;
    rsp_cnt = 0;
    i_start = 1'b1;
    i_opcode = op;
    i_len = len;
    @(negedge i_clk);
    i_start = 1'b0;
    cnt = 0;
    while (o_done !== 1'b1 && cnt < 40000) begin
      @(posedge i_clk);
      #1;
      cnt++;
    end
    chk("done", 8'h01, {7'h00, o_done});
    repeat (3) @(negedge i_clk);
    es = (!known(op) || nak || bad_xor) ? 8'hFF : st;
    el = (es == 8'h00) ? rl : 5'h00;
    chk("status", es, o_status);
    chk("rsp len", {3'h0, el}, {3'h0, o_rsp_len});
    chk("frames", fr + (!known(op) ? 8'h00 : nak ? 8'h03 : chat ? 8'h02 : 8'h01), m_fr);
    if (es != 8'hFF) chk("rsp count", {3'h0, el}, 8'(rsp_cnt));
    for (int k = 0; k < el; k++) chk("rsp byte", exp_seq ^ 8'hA5 ^ 8'(k), rsp_mem[k]);
    if (known(op) && !nak) begin
      chk("cmd seq", exp_seq, m_seq);
      chk("cmd op", op, m_op);
      chk("cmd len", {3'h0, len}, m_len);
      chk("cmd data", px, m_px);
      chk("cmd check", 8'h01, {7'h00, m_ok});
    end
    // Any valid answer moves the number on, faults keep it
    if (es != 8'hFF) exp_seq++;
    chk("seq", exp_seq, o_seq);
    $display("test op %h len %0d status %h finished", op, len, o_status);
  endtask
  // Main sequence: two corners, then every opcode at random sizes, then fault corners
  initial begin
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    xfer(8'h62, 5'h16, 8'h00, 5'h10);
    xfer(8'h3F, 5'h00, 8'h00, 5'h00);
    for (int i = 0; i < 21; i++) begin
      xfer(ops[i], 5'({$random(seed)} % 6), (i % 5 == 4) ? 8'h09 : 8'h00,
        5'({$random(seed)} % 4));
    end
    xfer(8'h50, 5'h03, 8'h00, 5'h02);
    nak = 1'b1;
    xfer(8'h41, 5'h01, 8'h00, 5'h02);
    nak = 1'b0;
    bad_xor = 1'b1;
    xfer(8'h46, 5'h01, 8'h00, 5'h10);
    bad_xor = 1'b0;
    chat = 1'b1;
    xfer(8'h47, 5'h02, 8'h00, 5'h01);
    chat = 1'b0;
    dev_dly = 16'h05DC;
    xfer(8'h60, 5'h04, 8'h00, 5'h01);
    report_and_stop();
  end
  // Hang guard, about 1.4 times the expected run length
  initial begin
    repeat (90000) @(posedge i_clk);
    $display("[ERR] watchdog expected finish seen hang");
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
